// ==== hdl/slave_port_qos_consts.svh ====
// Functional notes
// - non-secure access needs access override bit
// - write average rate fraction in bits 5:0
// - combined peak rate fraction in bits 5:0
// - combined burst allowance in bits 13:0
// - combined average rate fraction in bits 13:0
// - soft target overspend count in bits 31:28
// - soft target burst allowance in bits 27:14
// - soft target bandwidth share in bits 13:8
// - read qos clamped to read min/max
// - write qos clamped to write min/max
// - combined min/max clamps read and write qos
// - write soft target mirrors read layout
// - read override enable drives read partition field
// - read override forced when the port lacks and the fabric has partition support
// - write override enable drives write partition field
// - write override forced when the port lacks and the fabric has partition support
// - one register copy per slave port
`ifndef SLAVE_PORT_QOS_CONSTS_SVH
`define SLAVE_PORT_QOS_CONSTS_SVH

// register index within a port window, address bits 5:2
`define IDX_SEC_ACC 4'h0
`define IDX_WR_AVG 4'h1
`define IDX_COMB_PEAK 4'h2
`define IDX_COMB_BURST 4'h3
`define IDX_COMB_AVG 4'h4
`define IDX_RD_SOFT 4'h5
`define IDX_WR_SOFT 4'h6
`define IDX_COMB_SOFT 4'h7
`define IDX_RD_PART 4'h8
`define IDX_WR_PART 4'h9
`define IDX_SOFT_EN 4'hA

// port window: address bits above this select the port
`define PORT_SHIFT 6

// field widths and positions
`define RATE_W 6
`define FRAC_W 14
`define QOS_W 4
`define PART_W 11
`define SEC_W 2
`define SOFT_EN_W 3
`define SOFT_CFG_W 24
`define SEC_NS_OVR_BIT 0
`define SOFT_OVR_MSB 31
`define SOFT_OVR_LSB 28
`define SOFT_BURST_MSB 27
`define SOFT_BURST_LSB 14
`define SOFT_SHARE_MSB 13
`define SOFT_SHARE_LSB 8
`define SOFT_QMIN_MSB 7
`define SOFT_QMIN_LSB 4
`define SOFT_QMAX_MSB 3
`define SOFT_QMAX_LSB 0
`define PART_EN_BIT 0
`define PART_VAL_MSB 11
`define PART_VAL_LSB 1
`define SOFT_EN_RD_BIT 0
`define SOFT_EN_WR_BIT 1
`define SOFT_EN_COMB_BIT 2

// reset values
`define RST_RATE 6'h00
`define RST_FRAC 14'h0000
`define RST_SOFT 32'h0000_0000
`define RST_PART 12'h000
`define RST_SEC 2'h0
`define RST_SOFT_EN 3'h0

`endif

// ==== hdl/slave_port_qos_pkg.sv ====
`include "slave_port_qos_consts.svh"
package slave_port_qos_pkg;

  // register copy held for one slave port
  typedef struct packed {
    logic [`SEC_W-1:0] sec_acc;
    logic [`RATE_W-1:0] wr_avg;
    logic [`RATE_W-1:0] comb_peak;
    logic [`FRAC_W-1:0] comb_burst;
    logic [`FRAC_W-1:0] comb_avg;
    logic [31:0] rd_soft;
    logic [31:0] wr_soft;
    logic [31:0] comb_soft;
    logic [`PART_W:0] rd_part;
    logic [`PART_W:0] wr_part;
    logic [`SOFT_EN_W-1:0] soft_en;
  } port_regs_t;

endpackage

// ==== hdl/qos_clamp.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "slave_port_qos_consts.svh"
module qos_clamp
(
  // request qos and bounds
  input wire logic [`QOS_W-1:0] qos_i,
  input wire logic [`QOS_W-1:0] qmin_i,
  input wire logic [`QOS_W-1:0] qmax_i,
  input wire logic en_i,
  // bounded qos
  output logic [`QOS_W-1:0] qos_o
);

  logic [`QOS_W-1:0] lo;

  // raise to minimum, then cap at maximum; maximum wins if bounds cross
  always_comb
  begin
    lo = (qos_i < qmin_i) ? qmin_i : qos_i;
    qos_o = qos_i;
    if (en_i)
    begin
      qos_o = (lo > qmax_i) ? qmax_i : lo;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/slave_port_qos_mpam_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "slave_port_qos_consts.svh"
module slave_port_qos_mpam_regs
  import slave_port_qos_pkg::*;
#(
  parameter int NPORTS = 2,
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // register port
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_STB_I,
  input wire logic RD_STB_I,
  input wire logic SECURE_I,
  output logic [31:0] RDATA_O,
  output logic ACC_ERR_O,
  // qos of upstream requests
  input wire logic [NPORTS*`QOS_W-1:0] AR_QOS_I,
  input wire logic [NPORTS*`QOS_W-1:0] AW_QOS_I,
  output logic [NPORTS*`QOS_W-1:0] AR_QOS_O,
  output logic [NPORTS*`QOS_W-1:0] AW_QOS_O,
  // partitioning fields toward the fabric side
  input wire logic [NPORTS*`PART_W-1:0] AR_PART_I,
  input wire logic [NPORTS*`PART_W-1:0] AW_PART_I,
  input wire logic [NPORTS-1:0] PORT_PART_SUPPORT_I,
  input wire logic FABRIC_PART_SUPPORT_I,
  output logic [NPORTS*`PART_W-1:0] AR_PART_O,
  output logic [NPORTS*`PART_W-1:0] AW_PART_O,
  // regulator settings
  output logic [NPORTS*`RATE_W-1:0] WR_AVG_RATE_O,
  output logic [NPORTS*`RATE_W-1:0] COMB_PEAK_RATE_O,
  output logic [NPORTS*`FRAC_W-1:0] COMB_BURST_O,
  output logic [NPORTS*`FRAC_W-1:0] COMB_AVG_RATE_O,
  output logic [NPORTS*`SOFT_CFG_W-1:0] RD_SOFT_CFG_O,
  output logic [NPORTS*`SOFT_CFG_W-1:0] WR_SOFT_CFG_O,
  output logic [NPORTS*`SOFT_CFG_W-1:0] COMB_SOFT_CFG_O
);

  localparam int PIDX_W = ADDR_W - `PORT_SHIFT;

  typedef struct packed {
    port_regs_t [NPORTS-1:0] regs;
    logic [31:0] rdata;
    logic err;
    logic [NPORTS*`QOS_W-1:0] arq;
    logic [NPORTS*`QOS_W-1:0] awq;
    logic [NPORTS*`PART_W-1:0] arp;
    logic [NPORTS*`PART_W-1:0] awp;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [PIDX_W-1:0] pidx;
  logic [3:0] ridx;
  logic port_hit;
  logic reg_hit;
  logic allowed;
  logic [NPORTS*`QOS_W-1:0] arq_mid;
  logic [NPORTS*`QOS_W-1:0] arq_fin;
  logic [NPORTS*`QOS_W-1:0] awq_mid;
  logic [NPORTS*`QOS_W-1:0] awq_fin;

  function automatic logic [31:0] read_word(input port_regs_t p, input logic [3:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    // only implemented bits are returned, the rest read zero
    case (idx)
      `IDX_SEC_ACC: w[`SEC_W-1:0] = p.sec_acc;
      `IDX_WR_AVG: w[`RATE_W-1:0] = p.wr_avg;
      `IDX_COMB_PEAK: w[`RATE_W-1:0] = p.comb_peak;
      `IDX_COMB_BURST: w[`FRAC_W-1:0] = p.comb_burst;
      `IDX_COMB_AVG: w[`FRAC_W-1:0] = p.comb_avg;
      `IDX_RD_SOFT: w = p.rd_soft;
      `IDX_WR_SOFT: w = p.wr_soft;
      `IDX_COMB_SOFT: w = p.comb_soft;
      `IDX_RD_PART: w[`PART_W:0] = p.rd_part;
      `IDX_WR_PART: w[`PART_W:0] = p.wr_part;
      `IDX_SOFT_EN: w[`SOFT_EN_W-1:0] = p.soft_en;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  function automatic port_regs_t write_word(input port_regs_t p, input logic [3:0] idx,
                                            input logic [31:0] d);
    port_regs_t q;
    q = p;
    // reserved bits above each field are dropped
    case (idx)
      `IDX_SEC_ACC: q.sec_acc = d[`SEC_W-1:0];
      `IDX_WR_AVG: q.wr_avg = d[`RATE_W-1:0];
      `IDX_COMB_PEAK: q.comb_peak = d[`RATE_W-1:0];
      `IDX_COMB_BURST: q.comb_burst = d[`FRAC_W-1:0];
      `IDX_COMB_AVG: q.comb_avg = d[`FRAC_W-1:0];
      `IDX_RD_SOFT: q.rd_soft = d;
      `IDX_WR_SOFT: q.wr_soft = d;
      `IDX_COMB_SOFT: q.comb_soft = d;
      `IDX_RD_PART: q.rd_part = d[`PART_W:0];
      `IDX_WR_PART: q.wr_part = d[`PART_W:0];
      `IDX_SOFT_EN: q.soft_en = d[`SOFT_EN_W-1:0];
      default: q = p;
    endcase
    return q;
  endfunction

  // qos bounding per port: own soft target first, then the combined one
  for (genvar g = 0; g < NPORTS; g++)
  begin : g_port
    qos_clamp u_rd
    (
      .qos_i(AR_QOS_I[g*`QOS_W +: `QOS_W]),
      .qmin_i(st_r.regs[g].rd_soft[`SOFT_QMIN_MSB:`SOFT_QMIN_LSB]),
      .qmax_i(st_r.regs[g].rd_soft[`SOFT_QMAX_MSB:`SOFT_QMAX_LSB]),
      .en_i(st_r.regs[g].soft_en[`SOFT_EN_RD_BIT]),
      .qos_o(arq_mid[g*`QOS_W +: `QOS_W])
    );
    qos_clamp u_rd_comb
    (
      .qos_i(arq_mid[g*`QOS_W +: `QOS_W]),
      .qmin_i(st_r.regs[g].comb_soft[`SOFT_QMIN_MSB:`SOFT_QMIN_LSB]),
      .qmax_i(st_r.regs[g].comb_soft[`SOFT_QMAX_MSB:`SOFT_QMAX_LSB]),
      .en_i(st_r.regs[g].soft_en[`SOFT_EN_COMB_BIT]),
      .qos_o(arq_fin[g*`QOS_W +: `QOS_W])
    );
    qos_clamp u_wr
    (
      .qos_i(AW_QOS_I[g*`QOS_W +: `QOS_W]),
      .qmin_i(st_r.regs[g].wr_soft[`SOFT_QMIN_MSB:`SOFT_QMIN_LSB]),
      .qmax_i(st_r.regs[g].wr_soft[`SOFT_QMAX_MSB:`SOFT_QMAX_LSB]),
      .en_i(st_r.regs[g].soft_en[`SOFT_EN_WR_BIT]),
      .qos_o(awq_mid[g*`QOS_W +: `QOS_W])
    );
    qos_clamp u_wr_comb
    (
      .qos_i(awq_mid[g*`QOS_W +: `QOS_W]),
      .qmin_i(st_r.regs[g].comb_soft[`SOFT_QMIN_MSB:`SOFT_QMIN_LSB]),
      .qmax_i(st_r.regs[g].comb_soft[`SOFT_QMAX_MSB:`SOFT_QMAX_LSB]),
      .en_i(st_r.regs[g].soft_en[`SOFT_EN_COMB_BIT]),
      .qos_o(awq_fin[g*`QOS_W +: `QOS_W])
    );

    // settings straight from the per-port copies
    assign WR_AVG_RATE_O[g*`RATE_W +: `RATE_W] = st_r.regs[g].wr_avg;
    assign COMB_PEAK_RATE_O[g*`RATE_W +: `RATE_W] = st_r.regs[g].comb_peak;
    assign COMB_BURST_O[g*`FRAC_W +: `FRAC_W] = st_r.regs[g].comb_burst;
    assign COMB_AVG_RATE_O[g*`FRAC_W +: `FRAC_W] = st_r.regs[g].comb_avg;
    assign RD_SOFT_CFG_O[g*`SOFT_CFG_W +: `SOFT_CFG_W] = st_r.regs[g].rd_soft[31:8];
    assign WR_SOFT_CFG_O[g*`SOFT_CFG_W +: `SOFT_CFG_W] = st_r.regs[g].wr_soft[31:8];
    assign COMB_SOFT_CFG_O[g*`SOFT_CFG_W +: `SOFT_CFG_W] = st_r.regs[g].comb_soft[31:8];
  end

  // address decode
  always_comb
  begin
    pidx = ADDR_I[ADDR_W-1:`PORT_SHIFT];
    ridx = ADDR_I[`PORT_SHIFT-1:2];
    port_hit = (int'(pidx) < NPORTS);
    reg_hit = port_hit && (ridx <= `IDX_SOFT_EN);
    allowed = 1'b0;
    if (reg_hit)
    begin
      if (ridx == `IDX_SEC_ACC)
      begin
        allowed = SECURE_I;
      end
      else
      begin
        allowed = SECURE_I || st_r.regs[pidx].sec_acc[`SEC_NS_OVR_BIT];
      end
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = 32'h0000_0000;
    st_nxt.err = 1'b0;
    if (WR_STB_I)
    begin
      if (allowed)
      begin
        st_nxt.regs[pidx] = write_word(st_r.regs[pidx], ridx, WDATA_I);
      end
      else
      begin
        st_nxt.err = 1'b1;
      end
    end
    if (RD_STB_I)
    begin
      if (allowed)
      begin
        st_nxt.rdata = read_word(st_r.regs[pidx], ridx);
      end
      else
      begin
        st_nxt.err = 1'b1;
      end
    end
    st_nxt.arq = arq_fin;
    st_nxt.awq = awq_fin;
    for (int i = 0; i < NPORTS; i++)
    begin
      st_nxt.arp[i*`PART_W +: `PART_W] = AR_PART_I[i*`PART_W +: `PART_W];
      st_nxt.awp[i*`PART_W +: `PART_W] = AW_PART_I[i*`PART_W +: `PART_W];
      if (st_r.regs[i].rd_part[`PART_EN_BIT] ||
          (!PORT_PART_SUPPORT_I[i] && FABRIC_PART_SUPPORT_I))
      begin
        st_nxt.arp[i*`PART_W +: `PART_W] =
          st_r.regs[i].rd_part[`PART_VAL_MSB:`PART_VAL_LSB];
      end
      if (st_r.regs[i].wr_part[`PART_EN_BIT] ||
          (!PORT_PART_SUPPORT_I[i] && FABRIC_PART_SUPPORT_I))
      begin
        st_nxt.awp[i*`PART_W +: `PART_W] =
          st_r.regs[i].wr_part[`PART_VAL_MSB:`PART_VAL_LSB];
      end
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      for (int i = 0; i < NPORTS; i++)
      begin
        st_r.regs[i].sec_acc <= `RST_SEC;
        st_r.regs[i].wr_avg <= `RST_RATE;
        st_r.regs[i].comb_peak <= `RST_RATE;
        st_r.regs[i].comb_burst <= `RST_FRAC;
        st_r.regs[i].comb_avg <= `RST_FRAC;
        st_r.regs[i].rd_soft <= `RST_SOFT;
        st_r.regs[i].wr_soft <= `RST_SOFT;
        st_r.regs[i].comb_soft <= `RST_SOFT;
        st_r.regs[i].rd_part <= `RST_PART;
        st_r.regs[i].wr_part <= `RST_PART;
        st_r.regs[i].soft_en <= `RST_SOFT_EN;
      end
      st_r.rdata <= 32'h0000_0000;
      st_r.err <= 1'b0;
      st_r.arq <= '0;
      st_r.awq <= '0;
      st_r.arp <= '0;
      st_r.awp <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign RDATA_O = st_r.rdata;
  assign ACC_ERR_O = st_r.err;
  assign AR_QOS_O = st_r.arq;
  assign AW_QOS_O = st_r.awq;
  assign AR_PART_O = st_r.arp;
  assign AW_PART_O = st_r.awp;

endmodule
`default_nettype wire

// ==== testbench/slave_port_qos_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module slave_port_qos_monitor #(
  parameter int NPORTS = 2,
  parameter int ADDR_W = 12
)
(
  // register port
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_STB_I,
  input wire logic RD_STB_I,
  input wire logic SECURE_I,
  input wire logic [31:0] RDATA_O,
  input wire logic ACC_ERR_O,
  // partition and rate paths
  input wire logic [NPORTS*11-1:0] AR_PART_I,
  input wire logic [NPORTS*11-1:0] AW_PART_I,
  input wire logic [NPORTS-1:0] PORT_PART_SUPPORT_I,
  input wire logic FABRIC_PART_SUPPORT_I,
  input wire logic [NPORTS*11-1:0] AR_PART_O,
  input wire logic [NPORTS*11-1:0] AW_PART_O,
  input wire logic [NPORTS*6-1:0] WR_AVG_RATE_O
);
  logic ns_ok_r, p0, wok, fz;
  logic [11:0] ar_ov_r, aw_ov_r;
  assign p0 = (ADDR_I[ADDR_W-1:6] == '0);
  assign wok = WR_STB_I && p0 && (SECURE_I || ns_ok_r);
  assign fz = !PORT_PART_SUPPORT_I[0] && FABRIC_PART_SUPPORT_I;
  // shadow of port 0 override and access control
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      ns_ok_r <= 1'b0;
      ar_ov_r <= 12'h000;
      aw_ov_r <= 12'h000;
    end
    else
    begin
      if (wok && SECURE_I && ADDR_I[5:0] == 6'h00)
        ns_ok_r <= WDATA_I[0];
      if (wok && ADDR_I[5:0] == 6'h20)
        ar_ov_r <= WDATA_I[11:0];
      if (wok && ADDR_I[5:0] == 6'h24)
        aw_ov_r <= WDATA_I[11:0];
    end
  end
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  sequence s_ns_ctl_rd;
    RD_STB_I && !SECURE_I && ADDR_I[5:2] == 4'h0;
  endsequence
  sequence s_refused;
    ACC_ERR_O && RDATA_O == 32'h0;
  endsequence
  chk_rdata_idle: assert property (!$past(RD_STB_I) |-> RDATA_O == 32'h0)
    else $error("read data outside read cycle");
  chk_err_cause: assert property (ACC_ERR_O |-> $past(WR_STB_I || RD_STB_I))
    else $error("access error without access");
  chk_ns_refused: assert property (s_ns_ctl_rd |=> s_refused)
    else $error("non-secure control read not refused");
  chk_idx_unmapped: assert property (
    (WR_STB_I || RD_STB_I) && ADDR_I[5:2] > 4'hA |=> ACC_ERR_O)
    else $error("unmapped access not refused");
  chk_avg_write: assert property (
    WR_STB_I && SECURE_I && p0 && ADDR_I[5:2] == 4'h1
    |=> WR_AVG_RATE_O[5:0] == $past(WDATA_I[5:0]))
    else $error("write average rate not stored");
  chk_avg_rsvd: assert property (
    RD_STB_I && SECURE_I && ADDR_I[5:2] == 4'h1 |=> RDATA_O[31:6] == 26'h0)
    else $error("reserved bits not zero");
  chk_ar_part: assert property (
    $past(RSTN_I) |->
    AR_PART_O[10:0] == $past((ar_ov_r[0] || fz) ? ar_ov_r[11:1] : AR_PART_I[10:0]))
    else $error("read partition field wrong");
  chk_aw_part: assert property (
    $past(RSTN_I) |->
    AW_PART_O[10:0] == $past((aw_ov_r[0] || fz) ? aw_ov_r[11:1] : AW_PART_I[10:0]))
    else $error("write partition field wrong");
endmodule
bind slave_port_qos_mpam_regs slave_port_qos_monitor #(.NPORTS(NPORTS), .ADDR_W(ADDR_W))
  u_slave_port_qos_monitor (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_STB_I(WR_STB_I), .RD_STB_I(RD_STB_I), .SECURE_I(SECURE_I),
  .RDATA_O(RDATA_O), .ACC_ERR_O(ACC_ERR_O), .AR_PART_I(AR_PART_I), .AW_PART_I(AW_PART_I),
  .PORT_PART_SUPPORT_I(PORT_PART_SUPPORT_I), .FABRIC_PART_SUPPORT_I(FABRIC_PART_SUPPORT_I),
  .AR_PART_O(AR_PART_O), .AW_PART_O(AW_PART_O), .WR_AVG_RATE_O(WR_AVG_RATE_O));
`default_nettype wire

// ==== testbench/upstream_master_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module upstream_master_model #(
  parameter int NPORTS = 2
)
(
  // values to issue
  input wire logic [3:0] QOS_I,
  input wire logic [10:0] PART_I,
  // request fields, every port alike
  output logic [NPORTS*4-1:0] AR_QOS_O,
  output logic [NPORTS*4-1:0] AW_QOS_O,
  output logic [NPORTS*11-1:0] AR_PART_O,
  output logic [NPORTS*11-1:0] AW_PART_O
);
  assign AR_QOS_O = {NPORTS{QOS_I}};
  assign AW_QOS_O = {NPORTS{QOS_I}};
  assign AR_PART_O = {NPORTS{PART_I}};
  assign AW_PART_O = {NPORTS{~PART_I}};
endmodule
`default_nettype wire

// ==== testbench/slave_port_qos_mpam_regs_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module slave_port_qos_mpam_regs_tb_top;
  logic clk, rstn, wr, rd, sec, fab, err;
  logic [11:0] addr, wavg, cpk;
  logic [31:0] wdata, rdata;
  logic [1:0] psup;
  logic [3:0] qv;
  logic [10:0] pv;
  logic [7:0] arq_i, awq_i, arq, awq;
  logic [21:0] arp_i, awp_i, arp, awp;
  logic [27:0] cbur, cavg;
  logic [47:0] rsoft, wsoft, csoft;
  int error_cnt = 0;
  int total_checks = 0;
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  upstream_master_model u_upstream_master_model (.QOS_I(qv), .PART_I(pv),
    .AR_QOS_O(arq_i), .AW_QOS_O(awq_i), .AR_PART_O(arp_i), .AW_PART_O(awp_i));
  slave_port_qos_mpam_regs u_slave_port_qos_mpam_regs (.CLK_I(clk), .RSTN_I(rstn),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_STB_I(wr), .RD_STB_I(rd), .SECURE_I(sec),
    .RDATA_O(rdata), .ACC_ERR_O(err), .AR_QOS_I(arq_i), .AW_QOS_I(awq_i),
    .AR_QOS_O(arq), .AW_QOS_O(awq), .AR_PART_I(arp_i), .AW_PART_I(awp_i),
    .PORT_PART_SUPPORT_I(psup), .FABRIC_PART_SUPPORT_I(fab), .AR_PART_O(arp),
    .AW_PART_O(awp), .WR_AVG_RATE_O(wavg), .COMB_PEAK_RATE_O(cpk), .COMB_BURST_O(cbur),
    .COMB_AVG_RATE_O(cavg), .RD_SOFT_CFG_O(rsoft), .WR_SOFT_CFG_O(wsoft),
    .COMB_SOFT_CFG_O(csoft));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic wr32(input logic [11:0] a, input logic [31:0] d, input logic s);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    sec <= s;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd32(input logic [11:0] a, input logic s, input logic [31:0] e,
    input logic ee);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    sec <= s;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp("rdata", e, rdata);
    cmp("acc_err", {31'h0, ee}, {31'h0, err});
  endtask
  task automatic tq(input logic [3:0] q, input logic [3:0] ea, input logic [3:0] ew);
    @(posedge clk);
    qv <= q;
    repeat (3) @(posedge clk);
    #1;
    cmp("ar_qos", ea, arq[3:0]);
    cmp("aw_qos", ew, awq[3:0]);
  endtask
  task automatic tp(input logic [11:0] a, input logic [11:0] w, input logic [10:0] ea,
    input logic [10:0] ew);
    wr32(12'h020, a, 1'b1);
    wr32(12'h024, w, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    cmp("ar_part", ea, arp[10:0]);
    cmp("aw_part", ew, awp[10:0]);
  endtask
  task automatic t_hard;
    rd32(12'h004, 1'b1, 32'h0, 1'b0);
    for (int i = 1; i < 5; i++)
    begin
      wr32(12'(i * 4), 32'hFFFF_FFFF, 1'b1);
    end
    for (int i = 1; i < 5; i++)
    begin
      rd32(12'(i * 4), 1'b1, (i < 3) ? 32'h3F : 32'h3FFF, 1'b0);
    end
    wr32(12'h044, 32'h15, 1'b1);
    rd32(12'h004, 1'b1, 32'h3F, 1'b0);
    rd32(12'h044, 1'b1, 32'h15, 1'b0);
    cmp("wr_avg", 32'h57F, {20'h0, wavg});
    cmp("comb_burst", 32'h3FFF, {4'h0, cbur});
    cmp("comb_peak", 32'h03F, {20'h0, cpk});
    cmp("comb_avg", 32'h3FFF, {4'h0, cavg});
  endtask
  task automatic t_soft;
    wr32(12'h014, 32'hA5C3_7E49, 1'b1);
    wr32(12'h018, 32'h5A3C_8137, 1'b1);
    wr32(12'h01C, 32'h1234_5656, 1'b1);
    rd32(12'h014, 1'b1, 32'hA5C3_7E49, 1'b0);
    rd32(12'h018, 1'b1, 32'h5A3C_8137, 1'b0);
    rd32(12'h01C, 1'b1, 32'h1234_5656, 1'b0);
    cmp("rd_soft", 32'hA5C37E, {8'h0, rsoft[23:0]});
    cmp("wr_soft", 32'h5A3C81, {8'h0, wsoft[23:0]});
    cmp("comb_soft", 32'h123456, {8'h0, csoft[23:0]});
  endtask
  task automatic t_qos;
    wr32(12'h028, 32'h3, 1'b1);
    tq(4'h2, 4'h4, 4'h3);
    tq(4'hC, 4'h9, 4'h7);
    tq(4'h6, 4'h6, 4'h6);
    wr32(12'h028, 32'h7, 1'b1);
    tq(4'h2, 4'h5, 4'h5);
    tq(4'hC, 4'h6, 4'h6);
  endtask
  task automatic t_part;
    tp(12'h278, 12'h4D2, 11'h2A5, 11'h55A);
    tp(12'h279, 12'h4D3, 11'h13C, 11'h269);
    @(posedge clk);
    psup <= 2'b10;
    tp(12'h278, 12'h4D2, 11'h13C, 11'h269);
    @(posedge clk);
    fab <= 1'b0;
    tp(12'h278, 12'h4D2, 11'h2A5, 11'h55A);
  endtask
  task automatic t_sec;
    rd32(12'h004, 1'b0, 32'h0, 1'b1);
    wr32(12'h004, 32'h0, 1'b0);
    rd32(12'h004, 1'b1, 32'h3F, 1'b0);
    wr32(12'h000, 32'h1, 1'b1);
    wr32(12'h004, 32'h2A, 1'b0);
    rd32(12'h004, 1'b0, 32'h2A, 1'b0);
    rd32(12'h000, 1'b0, 32'h0, 1'b1);
    rd32(12'h000, 1'b1, 32'h1, 1'b0);
    rd32(12'h02C, 1'b1, 32'h0, 1'b1);
    rd32(12'h080, 1'b1, 32'h0, 1'b1);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    {rstn, wr, rd, sec, fab, addr, wdata, qv} = '0;
    psup = 2'b11;
    fab = 1'b1;
    pv = 11'h2A5;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_hard();
    t_soft();
    t_qos();
    t_part();
    t_sec();
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
